// *** rtl/eflc_pkg.sv ***
// Shared constants and types for the engine fault lamp link.
// Assumes one 10 MHz clock shared by both ends.
package eflc_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // Lamp request codes carried on the link.
  typedef enum logic [2:0] {
    EFLC_REQ_STEADY  = 3'h0,
    EFLC_REQ_OFF     = 3'h1,
    EFLC_REQ_FLASH1  = 3'h2,
    EFLC_REQ_FLASH2  = 3'h3,
    EFLC_REQ_FLASH05 = 3'h4
  } eflc_req_t;

  localparam logic [2:0] REQ_RESERVED_MIN = 3'h5;

  // Refresh periods and the loss timeout in milliseconds, and their cycle counts.
  localparam int unsigned LAMP_DELAY_MS  = 125;
  localparam int unsigned FAULT_DELAY_MS = 525;
  localparam int unsigned EMIS_DELAY_MS  = 1025;
  localparam int unsigned LOSS_MS        = 5000;
  localparam int unsigned LAMP_DELAY_CYC = LAMP_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned FAULT_DELAY_CYC = FAULT_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned EMIS_DELAY_CYC = EMIS_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned LOSS_CYC       = LOSS_MS * (CLK_HZ / 1000);

  // Flash base tick: quarter period of 2 Hz, i.e. 125 ms.
  localparam int unsigned TICK_MS  = 125;
  localparam int unsigned TICK_CYC = TICK_MS * (CLK_HZ / 1000);

  // Half periods in ticks for each flash rate.
  localparam logic [3:0] HALF_2HZ  = 4'h2;
  localparam logic [3:0] HALF_1HZ  = 4'h4;
  localparam logic [3:0] HALF_05HZ = 4'h8;

  localparam logic RESET_FAULT = 1'b0;
  localparam logic RESET_EMIS  = 1'b0;

endpackage

// *** rtl/eflc_link_if.sv ***
// Link between the engine controller end and the lamp receiver end.
// Assumes a frame strobe of one cycle carries all three signals.
`timescale 1ns/1ps
interface eflc_link_if;
  import eflc_pkg::*;
  logic       frame_vld;
  logic [2:0] lamp_req;
  logic       fault_stored;
  logic       emis_fault;

  modport engine_controller (
    output frame_vld,
    output lamp_req,
    output fault_stored,
    output emis_fault
  );
  modport receiver (
    input frame_vld,
    input lamp_req,
    input fault_stored,
    input emis_fault
  );
endinterface

// *** rtl/eflc_cycle_timer.sv ***
// Free-running divider that emits one-cycle ticks.
// Assumes a single clock with synchronous active-high reset.
`timescale 1ns/1ps
module eflc_cycle_timer #(
  parameter int unsigned PERIOD = 16
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  localparam int unsigned W = $clog2(PERIOD + 1);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Wrap at the period end and flag the wrap.
  always_comb begin
    tick_o  = (cnt_r == W'(PERIOD - 1));
    cnt_nxt = tick_o ? '0 : cnt_r + W'(1);
  end

  // Register the count.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// *** rtl/eflc_engine_end.sv ***
// Engine controller end: frames the lamp request and fault flags.
// Assumes the user side presents levels on the same clock.
`timescale 1ns/1ps
module eflc_engine_end #(
  parameter int unsigned FRAME_CYC = eflc_pkg::LAMP_DELAY_CYC
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                send_en_i,
  input  wire logic                fault_stored_i,
  input  wire logic                emis_fault_i,
  input  wire eflc_pkg::eflc_req_t lamp_req_i,
  eflc_link_if.engine_controller   link
);
  import eflc_pkg::*;
  logic       tick;
  logic [2:0] req_r;
  logic [2:0] req_nxt;
  logic       fault_r;
  logic       fault_nxt;
  logic       emis_r;
  logic       emis_nxt;
  logic       vld_r;
  logic       vld_nxt;

  eflc_cycle_timer #(.PERIOD(FRAME_CYC)) u_frame (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_o     (tick)
  );

  // Sample the user levels once per frame so fields stay coherent.
  always_comb begin
    vld_nxt   = tick & send_en_i;
    req_nxt   = req_r;
    fault_nxt = fault_r;
    emis_nxt  = emis_r;
    if (vld_nxt) begin
      req_nxt   = lamp_req_i;
      fault_nxt = fault_stored_i;
      emis_nxt  = emis_fault_i;
    end
  end

  // Register the frame so the link fields come straight from flops.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      vld_r   <= 1'b0;
      req_r   <= EFLC_REQ_STEADY;
      fault_r <= RESET_FAULT;
      emis_r  <= RESET_EMIS;
    end else begin
      vld_r   <= vld_nxt;
      req_r   <= req_nxt;
      fault_r <= fault_nxt;
      emis_r  <= emis_nxt;
    end
  end

  assign link.frame_vld    = vld_r;
  assign link.lamp_req     = req_r;
  assign link.fault_stored = fault_r;
  assign link.emis_fault   = emis_r;
endmodule

// *** rtl/eflc_lamp_receiver.sv ***
// Lamp receiver end: decodes frames into lamp and telltale drives.
// Assumes frames arrive from logic on the same clock.
// Bulb check, combine and the non-emissions flag come from that clock
// too, so no input here needs a synchroniser.
// Function
// - Stored-fault flag set for any fault code.
// - Stored-fault flag drives stored-fault telltale.
// - Telltale bulb check distinguishable, agreed both sides.
// - Sender refreshes emissions flag each 1025 ms; the engine end here sends it in every 125 ms frame.
// - Emissions flag never drives the lamp.
// - Emissions telltale gets bulb check, optional OR.
// - Lamp request is a 3-bit code.
// - Steady on for check, service, failures.
// - 1 Hz flash for catalyst or readiness.
// - 0.5 Hz flash during plant fuel prime.
// - Service uses on/off; sender sequences check.
// - Request drives only the lamp.
// - Power-up holds lamp steady on.
// - Flash toggles at rate, 50% duty.
// - Frames missing over 5 s: steady on.
// - Resume commanded state within 5 s.
// - Communication faults never light the lamp; here a frame loss over the limit forces the lamp steady on.
// - Crank follows command; loss resets steady.
`timescale 1ns/1ps
module eflc_lamp_receiver #(
  parameter int unsigned LOSS_LIMIT = eflc_pkg::LOSS_CYC,
  parameter int unsigned FLASH_TICK = eflc_pkg::TICK_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  eflc_link_if.receiver   link,
  input  wire logic       bulb_check_i,
  input  wire logic       combine_i,
  input  wire logic       non_emis_fault_i,
  output logic            engine_fault_lamp_o,
  output logic            service_soon_lamp_o,
  output logic            emis_telltale_o,
  output logic            comm_lost_o
);
  import eflc_pkg::*;

  // The loss counter must reach the limit itself, hence the plus one.
  localparam int unsigned LW = $clog2(LOSS_LIMIT + 1);

  // Flash base tick and frame tracking state.
  logic          tick;
  logic [2:0]    mode_r;
  logic [2:0]    mode_nxt;
  logic [LW-1:0] loss_r;
  logic [LW-1:0] loss_nxt;
  logic          lost_r;
  logic          lost_nxt;

  // Flash phase and lamp drive.
  logic [3:0]    ph_r;
  logic [3:0]    ph_nxt;
  logic          lamp_r;
  logic          lamp_nxt;

  // Latched fault flags and the two telltales.
  logic          fault_r;
  logic          fault_nxt;
  logic          emis_r;
  logic          emis_nxt;
  logic          svc_r;
  logic          svc_nxt;
  logic          etl_r;
  logic          etl_nxt;
  logic          good;

  // A frame counts only when it carries one of the defined codes.
  function automatic logic code_ok(input logic [2:0] code);
    code_ok = (code < REQ_RESERVED_MIN);
  endfunction

  // Half period in base ticks of a flashing code, zero when steady.
  // Reserved codes never reach the mode register; zero keeps them inert.
  function automatic logic [3:0] half_of(input logic [2:0] code);
    unique case (code)
      EFLC_REQ_FLASH2:  half_of = HALF_2HZ;
      EFLC_REQ_FLASH1:  half_of = HALF_1HZ;
      EFLC_REQ_FLASH05: half_of = HALF_05HZ;
      default:          half_of = 4'h0;
    endcase
  endfunction

  // The divider runs free so every flash edge lands on a tick.
  // Sharing one divider for all rates keeps their edges in step.
  eflc_cycle_timer #(.PERIOD(FLASH_TICK)) u_tick (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_o     (tick)
  );

  // A reserved code is refused whole: no mode change, no timer restart
  // and no flag latch. Holding the last state is safer than guessing
  // what a future flash rate should look like.
  assign good = link.frame_vld && code_ok(link.lamp_req);

  // Frame tracking and loss detection. A reset or loss lands on
  // steady on, so crank recovery needs no separate state. The counter
  // stops at the limit instead of wrapping, so a long outage can never
  // count its way back to a link that looks alive.
  always_comb begin
    mode_nxt = mode_r;
    loss_nxt = loss_r;
    lost_nxt = lost_r;
    if (good) begin
      mode_nxt = link.lamp_req;
      loss_nxt = '0;
      lost_nxt = 1'b0;
    end else if (loss_r == LW'(LOSS_LIMIT)) begin
      lost_nxt = 1'b1;
      mode_nxt = EFLC_REQ_STEADY;
    end else begin
      loss_nxt = loss_r + LW'(1);
    end
  end

  // Register the frame tracking state.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_r <= EFLC_REQ_STEADY;
      loss_r <= '0;
      lost_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      loss_r <= loss_nxt;
      lost_r <= lost_nxt;
    end
  end

  // Lamp drive. Flash phase counts ticks and flips the lamp every
  // half period, giving 50% duty. Loss state only forces steady on;
  // it never lights the lamp by itself beyond that default. A change
  // between two flash rates keeps the phase, so the first half period
  // after it may be short; every edge still lands on a tick.
  always_comb begin
    ph_nxt   = ph_r;
    lamp_nxt = lamp_r;
    unique case (mode_r)
      EFLC_REQ_OFF: begin
        lamp_nxt = 1'b0;
        ph_nxt   = 4'h0;
      end
      EFLC_REQ_FLASH1, EFLC_REQ_FLASH2, EFLC_REQ_FLASH05: begin
        if (tick) begin
          if (ph_r + 4'h1 >= half_of(mode_r)) begin
            ph_nxt   = 4'h0;
            lamp_nxt = ~lamp_r;
          end else begin
            ph_nxt = ph_r + 4'h1;
          end
        end
      end
      EFLC_REQ_STEADY: begin
        lamp_nxt = 1'b1;
        ph_nxt   = 4'h0;
      end
      default: begin
        lamp_nxt = 1'b1; // Unreachable codes fall back to lit.
        ph_nxt   = 4'h0;
      end
    endcase
  end

  // Register the flash phase and the lamp drive.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ph_r   <= 4'h0;
      lamp_r <= 1'b1;
    end else begin
      ph_r   <= ph_nxt;
      lamp_r <= lamp_nxt;
    end
  end

  // Telltales. Fault flags are latched per frame; a lost link keeps
  // the last values, so a link fault alone cannot light either telltale.
  // Bulb check lights both telltales for as long as it is held; its
  // timing is agreed with the sender so check and real fault differ.
  always_comb begin
    fault_nxt = good ? link.fault_stored : fault_r;
    emis_nxt  = good ? link.emis_fault : emis_r;
    svc_nxt   = fault_r | bulb_check_i;
    etl_nxt   = emis_r | (combine_i & non_emis_fault_i) | bulb_check_i;
  end

  // Register the latched flags and the telltale drives.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fault_r <= RESET_FAULT;
      emis_r  <= RESET_EMIS;
      svc_r   <= 1'b0;
      etl_r   <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      emis_r  <= emis_nxt;
      svc_r   <= svc_nxt;
      etl_r   <= etl_nxt;
    end
  end

  // The emissions flag has no path to the fault lamp, and the loss flag
  // is only reported: it reaches the lamp through the steady default.
  assign engine_fault_lamp_o = lamp_r;
  assign service_soon_lamp_o = svc_r;
  assign emis_telltale_o     = etl_r;
  assign comm_lost_o         = lost_r;
endmodule

// *** tb/eflc_assertions.sv ***
// Checker for the lamp link and the main receiver's fault lamp and loss flag.
// Assumes the bench places it beside the link of the first pair.
`timescale 1ns/1ps
module eflc_assertions (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       frame_vld_i,
  input wire logic [2:0] lamp_req_i,
  input wire logic       engine_fault_lamp_i,
  input wire logic       comm_lost_i
);
  // One clock domain, so clocking and disable are given once.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  frame_pulse_a: assert property (frame_vld_i |=> !frame_vld_i)
    else $error("frame strobe longer than one cycle");
  frame_gap_a: assert property (frame_vld_i |=> !frame_vld_i [*8])
    else $error("frames closer than the refresh period");
  req_legal_a: assert property (frame_vld_i |-> lamp_req_i < 3'h5)
    else $error("sender framed a reserved code");
  lamp_off_a: assert property (
    frame_vld_i && lamp_req_i == 3'h1 |-> ##2 !engine_fault_lamp_i)
    else $error("off request did not clear the lamp");
  lamp_steady_a: assert property (
    frame_vld_i && lamp_req_i == 3'h0 |-> ##2 engine_fault_lamp_i)
    else $error("steady request did not light the lamp");
  loss_lamp_a: assert property (
    $rose(comm_lost_i) |=> engine_fault_lamp_i)
    else $error("lamp not lit after frame loss");
  loss_hold_a: assert property (frame_vld_i |=> !comm_lost_i [*8])
    else $error("loss flagged while frames arrive");
  reset_default_a: assert property (
    $fell(rst_i) |-> engine_fault_lamp_i && !comm_lost_i)
    else $error("wrong lamp state after reset");
endmodule

// *** tb/tb_top.sv ***
// Bench joining both link ends, plus a receiver fed by the bench.
// Assumes the shortened counts set below at the instances.
`timescale 1ns/1ps
module tb_top;
  import eflc_pkg::*;
  localparam int LOSS = 200;
  localparam int FT   = 4;
  logic      core_clk_i, rst_i, send_en_i, fault_stored_i, emis_fault_i;
  logic      bulb_check_i, combine_i, non_emis_fault_i;
  eflc_req_t lamp_req_i;
  logic      fault_lamp, svc_lamp, emis_tt, lost, lamp2, lost2;
  int        mismatches, n_checks, n;
  // Rows: request, five flag inputs, then lamp, stored, emissions.
  localparam logic [10:0] ROWS [6] = '{11'h100, 11'h086, 11'h141,
                                       11'h119, 11'h123, 11'h108};
  eflc_link_if link ();
  eflc_link_if link2 ();
  eflc_engine_end #(.FRAME_CYC(20)) u_eflc_engine_end (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .send_en_i(send_en_i),
    .fault_stored_i(fault_stored_i), .emis_fault_i(emis_fault_i),
    .lamp_req_i(lamp_req_i), .link(link));
  eflc_lamp_receiver #(.LOSS_LIMIT(LOSS), .FLASH_TICK(FT))
    u_eflc_lamp_receiver (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .link(link), .bulb_check_i(bulb_check_i), .combine_i(combine_i),
    .non_emis_fault_i(non_emis_fault_i), .engine_fault_lamp_o(fault_lamp),
    .service_soon_lamp_o(svc_lamp), .emis_telltale_o(emis_tt),
    .comm_lost_o(lost));
  // The second receiver hears frames that only the bench makes.
  eflc_lamp_receiver #(.LOSS_LIMIT(LOSS), .FLASH_TICK(FT))
    u_eflc_lamp_receiver_2 (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .link(link2), .bulb_check_i(bulb_check_i), .combine_i(combine_i),
    .non_emis_fault_i(non_emis_fault_i), .engine_fault_lamp_o(lamp2),
    .service_soon_lamp_o(), .emis_telltale_o(), .comm_lost_o(lost2));
  eflc_assertions u_eflc_assertions (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .frame_vld_i(link.frame_vld),
    .lamp_req_i(link.lamp_req), .engine_fault_lamp_i(fault_lamp),
    .comm_lost_i(lost));

  task automatic end_sim();
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic s, input logic e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: saw %b expected %b", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask
  // Counts cycles to the next lamp edge; gives up after 200.
  task automatic tog(output int k);
    logic p;
    p = fault_lamp;
    k = 0;
    while (fault_lamp === p && k < 200) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic flash(input eflc_req_t c, input logic [3:0] h);
    lamp_req_i = c;
    cyc(30);
    tog(n);
    tog(n);
    chk(n == int'(h) * FT, 1'b1);
    tog(n);
    chk(n == int'(h) * FT, 1'b1);
  endtask

  // The clock runs at 10 MHz.
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // A hang costs a mismatch; the span is ten times the expected run.
  initial begin
    #(100 * 10000);
    mismatches++;
    end_sim();
  end
  initial begin
    {rst_i, send_en_i, fault_stored_i, emis_fault_i} = 4'h8;
    {bulb_check_i, combine_i, non_emis_fault_i} = 3'h0;
    lamp_req_i = EFLC_REQ_STEADY;
    {link2.frame_vld, link2.fault_stored, link2.emis_fault} = 3'h0;
    link2.lamp_req = 3'h0;
    cyc(10);
    chk(fault_lamp, 1'b1);
    chk(svc_lamp | emis_tt | lost | link.frame_vld, 1'b0);
    rst_i = 1'b0;
    send_en_i = 1'b1;
    foreach (ROWS[i]) begin
      lamp_req_i = eflc_req_t'(ROWS[i][10:8]);
      {fault_stored_i, emis_fault_i, bulb_check_i, combine_i,
       non_emis_fault_i} = ROWS[i][7:3];
      cyc(30);
      chk(fault_lamp, ROWS[i][2]);
      chk(svc_lamp, ROWS[i][1]);
      chk(emis_tt, ROWS[i][0]);
    end
    flash(EFLC_REQ_FLASH2, HALF_2HZ);
    flash(EFLC_REQ_FLASH1, HALF_1HZ);
    flash(EFLC_REQ_FLASH05, HALF_05HZ);
    // Stop framing right after a frame and let the loss timer run out.
    lamp_req_i = EFLC_REQ_OFF;
    cyc(30);
    n = 0;
    while (link.frame_vld !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(link.frame_vld, 1'b1);
    send_en_i = 1'b0;
    cyc(LOSS - 3);
    chk(lost | fault_lamp, 1'b0);
    cyc(8);
    chk(lost & fault_lamp, 1'b1);
    send_en_i = 1'b1;
    cyc(25);
    chk(lost | fault_lamp, 1'b0);
    // A reset in mid-run returns the lamp to steady until a new frame.
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    cyc(1);
    chk(fault_lamp, 1'b1);
    cyc(25);
    chk(fault_lamp, 1'b0);
    // Back-to-back frames, then reserved codes that must be ignored.
    link2.frame_vld = 1'b1;
    cyc(1);
    link2.lamp_req = 3'h1;
    for (int c = 5; c < 8; c++) begin
      cyc(1);
      link2.lamp_req = 3'(c);
    end
    cyc(1);
    link2.frame_vld = 1'b0;
    cyc(3);
    chk(lamp2, 1'b0);
    cyc(LOSS - 10);
    chk(lost2, 1'b0);
    cyc(6);
    chk(lost2, 1'b1);
    end_sim();
  end
endmodule
